// ==== logic/fswd_pkg.sv ====
// fswd_pkg: constants for the four-stage watchdog pair.
// Assumes one 10 MHz system clock and a word-wide register port.
package fswd_pkg;
  localparam int CLK_MHZ = 10;
  localparam int NCH = 2;
  localparam int CH_MAIN = 0;
  localparam int CH_AON = 1;
  localparam int STAGES = 4;
  localparam int CNT_W = 32;
  localparam int PRE_W = 16;
  localparam int ACT_W = 3;
  localparam int LEN_W = 3;
  localparam int PCNT_W = 6;
  localparam int ADDR_W = 8;
  // main watchdog counting clock period is the system clock period times the prescale value; this base period is unused
  localparam int BASE_PERIOD_PS = 12500;

  // per-watchdog register block, main at 0x00, always-on at 0x40
  localparam logic [ADDR_W-1:0] AON_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] BLK_MASK = 8'h3f;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRESCALE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TMO0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FEED = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_WKEY = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h24;

  // configuration word fields
  localparam int CFG_EN = 0;
  localparam int CFG_STG0 = 1;
  localparam int CFG_CPU_LEN = 13;
  localparam int CFG_SYS_LEN = 16;
  localparam int CFG_GUARD = 19;
  localparam int CFG_CORE0 = 20;
  localparam int CFG_CORE1 = 21;
  localparam logic [31:0] CFG_MASK_MAIN = 32'h000f_edb7;
  localparam logic [31:0] CFG_MASK_AON = 32'h003f_ffff;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] TMO_RESET = 32'h0000_0000;
  localparam logic [PRE_W-1:0] PRE_RESET = 16'h0001;
  localparam logic [31:0] WKEY_VALUE = 32'h50d8_3aa1;

  // stage actions; main watchdog fields are two bits wide, so chip reset cannot be coded there
  localparam logic [ACT_W-1:0] ACT_OFF = 3'h0;
  localparam logic [ACT_W-1:0] ACT_INT = 3'h1;
  localparam logic [ACT_W-1:0] ACT_CPU = 3'h2;
  localparam logic [ACT_W-1:0] ACT_SYS = 3'h3;
  localparam logic [ACT_W-1:0] ACT_CHIP = 3'h4;

  // reset pulse lengths in ns per length code
  localparam int RST_NS_0 = 100;
  localparam int RST_NS_1 = 200;
  localparam int RST_NS_2 = 300;
  localparam int RST_NS_3 = 400;
  localparam int RST_NS_4 = 500;
  localparam int RST_NS_5 = 800;
  localparam int RST_NS_6 = 1600;
  localparam int RST_NS_7 = 3200;

  function automatic logic [PCNT_W-1:0] fswd_len_cycles(input logic [LEN_W-1:0] code);
    int ns;
    int cyc;
    case (code)
      3'h0: ns = RST_NS_0;
      3'h1: ns = RST_NS_1;
      3'h2: ns = RST_NS_2;
      3'h3: ns = RST_NS_3;
      3'h4: ns = RST_NS_4;
      3'h5: ns = RST_NS_5;
      3'h6: ns = RST_NS_6;
      default: ns = RST_NS_7;
    endcase
    cyc = (ns * CLK_MHZ + 999) / 1000;
    if (cyc < 1) begin
      cyc = 1;
    end
    return PCNT_W'(cyc);
  endfunction
endpackage

// ==== logic/fswd_prescale.sv ====
// fswd_prescale: divides the system clock into a one-cycle counting tick.
// Assumes the divide value is held steady by its owner between writes.
`timescale 1ns/1ps
module fswd_prescale
  import fswd_pkg::*;
#(
  parameter int W = PRE_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic restart,
  input wire logic [W-1:0] divide,
  output logic tick
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  wire logic wrap;

  // a divide value of 0 or 1 ticks on every cycle
  assign wrap = (count + W'(1) >= divide);
  assign next_count = (restart || wrap) ? '0 : count + W'(1);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= wrap && !restart;
    end
  end
endmodule

// ==== logic/fswd_pulse.sv ====
// fswd_pulse: stretches one-cycle reset requests to a coded length.
// Assumes a new request during a pulse restarts that lane's length.
`timescale 1ns/1ps
module fswd_pulse
  import fswd_pkg::*;
#(
  parameter int LANES = 2
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [LANES-1:0] start,
  input wire logic [LEN_W-1:0] len_code,
  output logic [LANES-1:0] active
);
  wire logic [PCNT_W-1:0] len_cycles;

  assign len_cycles = fswd_len_cycles(len_code);

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [PCNT_W-1:0] left;
    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        left <= '0;
        active[l] <= 1'b0;
      end else if (start[l]) begin
        left <= len_cycles - PCNT_W'(1);
        active[l] <= 1'b1;
      end else if (left != '0) begin
        left <= left - PCNT_W'(1);
      end else begin
        active[l] <= 1'b0;
      end
    end
  end
endmodule

// ==== logic/fswd_top.sv ====
// fswd_top: main-system watchdog and always-on watchdog, each with four stages.
// Assumes slow_tick is a one-cycle strobe per slow-clock period, already in this domain.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
module fswd_top
  import fswd_pkg::*;
#(
  parameter bit SECOND_MAIN = 1'b0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic slow_tick,
  input wire logic boot_from_flash,
  output logic main_irq,
  output logic aon_irq,
  output logic first_core_reset,
  output logic second_core_reset,
  output logic main_system_reset,
  output logic chip_reset
);
  logic [31:0] cfg [NCH];
  logic [31:0] tmo [NCH][STAGES];
  logic [31:0] wkey [NCH];
  logic [CNT_W-1:0] count [NCH];
  logic [1:0] stage [NCH];
  logic [PRE_W-1:0] prescale;
  logic strap_done;
  logic [NCH-1:0] fire_int;
  logic [NCH-1:0] fire_cpu;
  logic [NCH-1:0] fire_sys;
  logic [NCH-1:0] fire_chip;
  logic [NCH-1:0] soft_clear;
  logic [1:0] cpu_start;
  logic [1:0] sys_start;
  logic [LEN_W-1:0] cpu_len;
  logic [LEN_W-1:0] sys_len;
  logic [1:0] cpu_active;
  logic [1:0] sys_active;
  logic [31:0] next_rdata;
  wire logic main_tick;
  wire logic [NCH-1:0] tick;
  wire logic sel_aon;
  wire logic [ADDR_W-1:0] ofs;
  wire logic [NCH-1:0] hit;
  wire logic [NCH-1:0] unlocked;
  wire logic [NCH-1:0] wr_ok;
  wire logic [NCH-1:0] feed;
  wire logic [NCH-1:0] eff_en;
  wire logic main_restart;

  assign sel_aon = reg_addr >= AON_BASE && reg_addr < AON_BASE + ADDR_W'(64);
  assign ofs = reg_addr & BLK_MASK;
  assign hit[CH_MAIN] = reg_addr < AON_BASE;
  assign hit[CH_AON] = sel_aon;
  assign main_restart = !eff_en[CH_MAIN] || feed[CH_MAIN];
  assign tick[CH_MAIN] = main_tick;
  assign tick[CH_AON] = slow_tick;

  fswd_prescale #(
    .W(PRE_W)
  ) u_prescale (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .restart(main_restart),
    .divide(prescale),
    .tick(main_tick)
  );

  // boot strap is caught on the first clock after reset release
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      strap_done <= 1'b0;
    end else begin
      strap_done <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn || soft_clear[CH_MAIN]) begin
      prescale <= PRE_RESET;
    end else if (wr_ok[CH_MAIN] && ofs == OFS_PRESCALE) begin
      prescale <= reg_wdata[PRE_W-1:0];
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_wd
    logic [ACT_W-1:0] act;
    logic [ACT_W-1:0] stg_act;
    wire logic expire;
    wire logic [31:0] cfg_mask;
    wire logic [31:0] stage_tmo;

    assign cfg_mask = (c == CH_MAIN) ? CFG_MASK_MAIN : CFG_MASK_AON;
    assign unlocked[c] = wkey[c] == WKEY_VALUE;
    assign wr_ok[c] = reg_wr && hit[c] && (unlocked[c] || ofs == OFS_WKEY);
    assign feed[c] = wr_ok[c] && ofs == OFS_FEED && ofs != OFS_WKEY;
    assign eff_en[c] = cfg[c][CFG_EN] || cfg[c][CFG_GUARD];
    assign stage_tmo = tmo[c][stage[c]];
    assign expire = eff_en[c] && tick[c] && count[c] == stage_tmo;

    always_comb begin
      stg_act = cfg[c][CFG_STG0 + 3 * stage[c] +: ACT_W];
      if (cfg[c][CFG_GUARD] && stage[c] == 2'd0) begin
        stg_act = (c == CH_MAIN) ? ACT_SYS : ACT_CHIP;
      end
      act = stg_act;
      if (c == CH_MAIN && stg_act == ACT_CHIP) begin
        act = ACT_OFF;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!resetn || soft_clear[c]) begin
        cfg[c] <= CFG_RESET;
        wkey[c] <= WKEY_VALUE;
      end else if (!strap_done) begin
        cfg[c][CFG_GUARD] <= boot_from_flash && (c == CH_AON || !SECOND_MAIN);
      end else if (wr_ok[c] && ofs == OFS_CFG) begin
        cfg[c] <= reg_wdata & cfg_mask;
      end else if (wr_ok[c] && ofs == OFS_WKEY) begin
        wkey[c] <= reg_wdata;
      end
    end

    for (genvar s = 0; s < STAGES; s++) begin : g_tmo
      always_ff @(posedge clk_sys) begin
        if (!resetn || soft_clear[c]) begin
          tmo[c][s] <= TMO_RESET;
        end else if (wr_ok[c] && ofs == OFS_TMO0 + ADDR_W'(4 * s)) begin
          tmo[c][s] <= reg_wdata;
        end
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!resetn || soft_clear[c]) begin
        count[c] <= '0;
        stage[c] <= 2'd0;
      end else if (feed[c] || !eff_en[c]) begin
        count[c] <= '0;
        stage[c] <= 2'd0;
      end else if (expire) begin
        count[c] <= '0;
        stage[c] <= stage[c] + 2'd1;
      end else if (tick[c]) begin
        count[c] <= count[c] + CNT_W'(1);
      end
    end

    // action strobes are registered so a self reset never loops back the same cycle
    always_ff @(posedge clk_sys) begin
      if (!resetn || soft_clear[c]) begin
        fire_int[c] <= 1'b0;
        fire_cpu[c] <= 1'b0;
        fire_sys[c] <= 1'b0;
        fire_chip[c] <= 1'b0;
      end else begin
        fire_int[c] <= expire && !feed[c] && act == ACT_INT;
        fire_cpu[c] <= expire && !feed[c] && act == ACT_CPU;
        fire_sys[c] <= expire && !feed[c] && act == ACT_SYS;
        fire_chip[c] <= expire && !feed[c] && act == ACT_CHIP;
      end
    end
  end

  // main watchdog is cleared by any system or chip reset, always-on only by its own chip reset
  always_comb begin
    soft_clear[CH_MAIN] = |sys_start;
    soft_clear[CH_AON] = sys_start[1];
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cpu_start <= 2'b00;
      sys_start <= 2'b00;
      cpu_len <= '0;
      sys_len <= '0;
    end else begin
      cpu_start[0] <= (fire_cpu[CH_MAIN] && !SECOND_MAIN) || (fire_cpu[CH_AON] && cfg[CH_AON][CFG_CORE0]);
      cpu_start[1] <= (fire_cpu[CH_MAIN] && SECOND_MAIN) || (fire_cpu[CH_AON] && cfg[CH_AON][CFG_CORE1]);
      sys_start[0] <= |fire_sys;
      sys_start[1] <= fire_chip[CH_AON];
      cpu_len <= fire_cpu[CH_MAIN] ? cfg[CH_MAIN][CFG_CPU_LEN +: LEN_W] : cfg[CH_AON][CFG_CPU_LEN +: LEN_W];
      sys_len <= |fire_sys[CH_MAIN] ? cfg[CH_MAIN][CFG_SYS_LEN +: LEN_W] : cfg[CH_AON][CFG_SYS_LEN +: LEN_W];
    end
  end

  fswd_pulse #(
    .LANES(2)
  ) u_cpu_pulse (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(cpu_start),
    .len_code(cpu_len),
    .active(cpu_active)
  );

  fswd_pulse #(
    .LANES(2)
  ) u_sys_pulse (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(sys_start),
    .len_code(sys_len),
    .active(sys_active)
  );

  // read mux; write-only and unmapped words read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int c = 0; c < NCH; c++) begin
      if (hit[c]) begin
        if (ofs == OFS_CFG) begin
          next_rdata = cfg[c];
        end else if (ofs == OFS_PRESCALE && c == CH_MAIN) begin
          next_rdata = {16'h0000, prescale};
        end else if (ofs >= OFS_TMO0 && ofs < OFS_FEED && ofs[1:0] == 2'b00) begin
          next_rdata = tmo[c][ofs[3:2] - 2'd2];
        end else if (ofs == OFS_WKEY) begin
          next_rdata = wkey[c];
        end else if (ofs == OFS_STATUS) begin
          next_rdata = {28'h000_0000, unlocked[c], eff_en[c], stage[c]};
        end else if (ofs == OFS_COUNT) begin
          next_rdata = count[c];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
      main_irq <= 1'b0;
      aon_irq <= 1'b0;
      first_core_reset <= 1'b0;
      second_core_reset <= 1'b0;
      main_system_reset <= 1'b0;
      chip_reset <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
      main_irq <= fire_int[CH_MAIN];
      aon_irq <= fire_int[CH_AON];
      first_core_reset <= cpu_active[0] || sys_active[0] || sys_active[1];
      second_core_reset <= cpu_active[1] || sys_active[0] || sys_active[1];
      main_system_reset <= sys_active[0] || sys_active[1];
      chip_reset <= sys_active[1];
    end
  end
endmodule

// ==== test/fswd_top_props.sv ====
// fswd_top_props: port-level checks for the watchdog pair.
// Assumes one clock and the synchronous active-low reset of fswd_top.
`timescale 1ns/1ps
module fswd_top_props
  import fswd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic slow_tick,
  input wire logic main_irq,
  input wire logic aon_irq,
  input wire logic first_core_reset,
  input wire logic second_core_reset,
  input wire logic main_system_reset,
  input wire logic chip_reset
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  wire any_out = main_irq | aon_irq | first_core_reset | second_core_reset | main_system_reset | chip_reset;

  key_readback_a: assert property (
    reg_wr && (reg_addr & BLK_MASK) == OFS_WKEY ##2 reg_rd && reg_addr == $past(reg_addr, 2)
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("key read back differs from key written");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  main_irq_pulse_a: assert property (main_irq |=> !main_irq)
    else $error("main interrupt longer than one cycle");
  aon_irq_pulse_a: assert property (aon_irq |=> !aon_irq)
    else $error("always-on interrupt longer than one cycle");
  aon_irq_cause_a: assert property (aon_irq |-> $past(slow_tick, 2) || $past(slow_tick, 3))
    else $error("always-on interrupt without a slow tick");
  // chip reset only from the always-on side, which needs a slow tick
  chip_slow_a: assert property ($rose(chip_reset) |-> $past(slow_tick, 2) || $past(slow_tick, 3)
    || $past(slow_tick, 4) || $past(slow_tick, 5)) else $error("chip reset without a slow tick");
  chip_sys_a: assert property ($rose(chip_reset) |-> ##[0:1] main_system_reset)
    else $error("chip reset without system reset");
  sys_cores_a: assert property ($rose(main_system_reset) |-> ##[0:1] (first_core_reset && second_core_reset))
    else $error("system reset without both core resets");
  reset_quiet_a: assert property (disable iff (1'b0) !resetn |=> !any_out)
    else $error("output active during reset");

  cover property ($rose(chip_reset));
  cover property ($rose(second_core_reset));
  cover property (main_irq);
endmodule

bind fswd_top fswd_top_props i_fswd_top_props (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .slow_tick, .main_irq, .aon_irq, .first_core_reset, .second_core_reset,
  .main_system_reset, .chip_reset);

// ==== test/tb_fswd_top.sv ====
// tb_fswd_top: random and directed checks of the watchdog pair at its ports.
// Assumes a 10 MHz clock and the register map of fswd_pkg.
`timescale 1ns/1ps
module tb_fswd_top
  import fswd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic slow_tick = 1'b0;
  logic boot_from_flash = 1'b0;
  logic tick_on = 1'b0;
  logic clr = 1'b0;
  logic [5:0] seen = 6'h00;
  logic [31:0] reg_rdata;
  logic main_irq, aon_irq, first_core_reset, second_core_reset, main_system_reset, chip_reset;
  wire [5:0] outs = {chip_reset, main_system_reset, second_core_reset, first_core_reset, aon_irq, main_irq};
  int bad_count = 0;
  int tests_run = 0;
  int lens[8] = '{1, 2, 3, 4, 5, 8, 16, 32};
  int n, p, exp_n;
  int tm[4];

  fswd_top #(.SECOND_MAIN(1'b0)) i_fswd_top (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .slow_tick, .boot_from_flash, .main_irq, .aon_irq, .first_core_reset, .second_core_reset,
    .main_system_reset, .chip_reset);

  always #50 clk_sys = ~clk_sys;
  // slow tick arrives at random spacing, sometimes back to back
  always @(posedge clk_sys) slow_tick <= tick_on && ($urandom_range(3) == 0);
  always @(posedge clk_sys) seen <= clr ? 6'h00 : (seen | outs);

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  // cycles until outs[k] is seen high; a hang ends the run
  task automatic wait_bit(input int k, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1 c++;
      if (c > lim) begin
        chk(32'h0000_0000, 32'h0000_0001);
        tally_and_finish();
      end
    end while (outs[k] !== 1'b1);
  endtask

  task automatic hi_len(input int k, output int c);
    c = 0;
    while (outs[k] === 1'b1 && c < 99) begin
      @(posedge clk_sys);
      #1 c++;
    end
  endtask

  task automatic do_reset(input logic boot);
    @(posedge clk_sys);
    resetn <= 1'b0;
    boot_from_flash <= boot;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
  endtask

  task automatic set_tmo(input logic [7:0] b, input int t);
    for (int s = 0; s < 4; s++) begin
      wr(b + OFS_TMO0 + 8'(4 * s), 32'(t));
    end
  endtask

  function automatic logic [31:0] acts(input logic [2:0] a0, a1, a2, a3);
    return {19'h0_0000, a3, a2, a1, a0, 1'b1};
  endfunction

  initial begin
    void'($urandom(79));
    do_reset(1'b0);
    for (int b = 0; b < 2; b++) begin
      rdchk((b == 1 ? AON_BASE : 8'h00) + OFS_WKEY, WKEY_VALUE);
      rdchk((b == 1 ? AON_BASE : 8'h00) + OFS_CFG, CFG_RESET);
      rdchk((b == 1 ? AON_BASE : 8'h00) + OFS_STATUS, 32'h0000_0008);
    end
    rdchk(OFS_PRESCALE, 32'h0000_0001);
    rdchk(8'h3c, 32'h0000_0000);
    tick_on <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rdchk(AON_BASE + OFS_COUNT, 32'h0000_0000);
    wr(OFS_CFG, 32'h0000_1248);
    rdchk(OFS_CFG, 32'h0000_1248 & CFG_MASK_MAIN);
    wr(AON_BASE + OFS_CFG, 32'h0000_1248);
    rdchk(AON_BASE + OFS_CFG, 32'h0000_1248);
    // locked block drops config writes but takes the key write
    wr(OFS_WKEY, 32'h0000_0000);
    wr(OFS_CFG, 32'h0000_0003);
    rdchk(OFS_STATUS, 32'h0000_0000);
    wr(OFS_WKEY, WKEY_VALUE);
    rdchk(OFS_WKEY, WKEY_VALUE);
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 0 : $urandom_range(4, 1);
      exp_n = 0;
      for (int s = 0; s < 4; s++) begin
        tm[s] = (i == 0) ? 0 : $urandom_range(5, 0);
        wr(OFS_TMO0 + 8'(4 * s), 32'(tm[s]));
        exp_n += tm[s] + 1;
      end
      wr(OFS_PRESCALE, 32'(p));
      wr(OFS_CFG, acts(ACT_INT, ACT_OFF, ACT_OFF, ACT_OFF));
      wait_bit(0, 999, n);
      wait_bit(0, 999, n);
      chk(32'(n), 32'((p < 2 ? 1 : p) * exp_n));
      wr(OFS_CFG, 32'h0000_0000);
    end
    wr(OFS_PRESCALE, 32'h0000_0001);
    wr(OFS_TMO0 + 8'h08, 32'h0000_00c8);
    wr(OFS_CFG, acts(ACT_INT, ACT_OFF, ACT_OFF, ACT_OFF));
    repeat (40) @(posedge clk_sys);
    wr(OFS_FEED, $urandom);
    wait_bit(0, 999, n);
    // feed restarts the prescaler, so the first tick lands two edges on, irq one edge after expiry
    chk(32'(n), 32'(3 + tm[0]));
    set_tmo(8'h00, 40);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CFG, acts(ACT_CPU, ACT_OFF, ACT_OFF, ACT_OFF) | (32'(c) << CFG_CPU_LEN));
      wait_bit(2, 999, n);
      hi_len(2, n);
      chk(32'(n), 32'(lens[c]));
      wr(OFS_CFG, 32'h0000_0000);
    end
    chk(32'(seen[5:3]), 32'h0000_0000);
    wr(OFS_CFG, acts(ACT_SYS, ACT_OFF, ACT_OFF, ACT_OFF) | (32'h7 << CFG_SYS_LEN));
    wait_bit(4, 999, n);
    hi_len(4, n);
    chk(32'(n), 32'(lens[7]));
    chk(32'(seen[3:2]), 32'h0000_0003);
    rdchk(OFS_CFG, 32'h0000_0000);
    rdchk(AON_BASE + OFS_CFG, 32'h0000_1248);
    set_tmo(AON_BASE, 0);
    for (int sel = 0; sel < 4; sel++) begin
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
      wr(AON_BASE + OFS_CFG, acts(ACT_CPU, ACT_INT, ACT_OFF, ACT_OFF) | (32'(sel) << CFG_CORE0));
      repeat (150) @(posedge clk_sys);
      wr(AON_BASE + OFS_CFG, 32'h0000_0000);
      repeat (20) @(posedge clk_sys);
      chk(32'(seen[3:1]), 32'((sel << 1) | 1));
    end
    wr(AON_BASE + OFS_CFG, acts(ACT_CHIP, ACT_OFF, ACT_OFF, ACT_OFF));
    wait_bit(5, 999, n);
    repeat (40) @(posedge clk_sys);
    rdchk(AON_BASE + OFS_CFG, 32'h0000_0000);
    // guard bit cleared before any slow tick: no chip reset may follow
    tick_on <= 1'b0;
    do_reset(1'b1);
    wr(AON_BASE + OFS_CFG, CFG_RESET);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    tick_on <= 1'b1;
    repeat (100) @(posedge clk_sys);
    chk(32'(seen[5]), 32'h0000_0000);
    tick_on <= 1'b0;
    do_reset(1'b1);
    rdchk(AON_BASE + OFS_STATUS, 32'h0000_000c);
    wait_bit(4, 30, n);
    tick_on <= 1'b1;
    wait_bit(5, 500, n);
    tally_and_finish();
  end
endmodule
